// [core/dual_release_compressor_pkg.sv]
// Purpose: constants for the dual release compressor
// Assumes: 24-bit signed stereo samples, AXI4-Lite register port
// Notes:   levels and gains are signed dB in steps of 1/256 dB; times in 0.1 ms
package dual_release_compressor_pkg;
   localparam int DW          = 24;
   localparam int AW          = 8;
   localparam int NREG        = 13;
   localparam int R_CTRL      = 0;
   localparam int R_RATIO     = 1;
   localparam int R_COMP_THR  = 2;
   localparam int R_REL_THR   = 3;
   localparam int R_ATK       = 4;
   localparam int R_REL_A     = 5;
   localparam int R_REL_B     = 6;
   localparam int R_SMOOTH    = 7;
   localparam int R_DLY       = 8;
   localparam int R_OUT_GAIN  = 9;
   localparam int R_MAKEUP    = 10;
   localparam int R_METER     = 11;
   localparam int R_STATUS    = 12;
   localparam int B_ACTIVE    = 0;
   localparam int B_FDBK      = 1;
   localparam int B_SRC       = 2;
   localparam int B_CHAN      = 4;
   localparam int B_OG_OFF    = 6;
   localparam int B_MU_OFF    = 7;
   localparam int B_INF       = 8;
   localparam logic [1:0] SEL_L = 2'h0;
   localparam logic [1:0] SEL_R = 2'h1;
   localparam logic [31:0] CTRL_RST  = 32'h0000_0001;
   localparam logic [31:0] RATIO_RST = 32'h0000_0010;
   localparam int DB_ONE      = 256;
   localparam int FRAC_W      = 8;
   localparam int THR_MIN     = -79 * DB_ONE;
   localparam int GAIN_MAX    = 24 * DB_ONE;
   localparam int FLOOR_DB    = -144 * DB_ONE;
   localparam int RATIO_UNITY = 16;
   localparam int RATIO_MAX   = 17 * RATIO_UNITY;
   localparam int T_REL_MAX   = 30000;
   localparam int T_SM_MAX    = 2280;
   localparam int T_DLY_MAX   = 250;
   localparam int TENTHS      = 10;
   localparam int Q_SH        = 16;
   localparam int ONE_Q16     = 65536;
   localparam int TIME_NUM    = ONE_Q16 * TENTHS;
   localparam int DB_PER_LOG2 = 1541;
   localparam int LOG2_PER_DB = 10885;
   localparam int KNEE_SH     = 11;
   localparam int DIV_STEPS   = 32;
   localparam int OP_DLY      = 4;
   localparam int OP_GAIN     = 5;
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// [core/delay_ram.sv]
// Purpose: sample memory for the main path predelay
// Assumes: one write and one read port on the same clock
// Notes:   read data registered every cycle, so a freshly written word is seen one edge later
`timescale 1ns/1ps
module delay_ram #(
   parameter int WIDTH = 48,
   parameter int DEPTH = 2048
)(
   input  wire logic                     aclk,
   input  wire logic                     we,
   input  wire logic [$clog2(DEPTH)-1:0] waddr,
   input  wire logic [WIDTH-1:0]         wdata,
   input  wire logic [$clog2(DEPTH)-1:0] raddr,
   output logic      [WIDTH-1:0]         rdata
);
   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge aclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
      rdata <= mem[raddr];
   end
endmodule

// [core/dual_release_compressor.sv]
// Purpose: stereo soft-knee compressor with two release times
// Assumes: one sample pair at a time; about 200 clocks of work per pair
// Notes:   levels and gains computed in the dB domain, applied to samples as a linear factor; one shared serial divider
//
// The register offsets and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
// Contract
// RULE1: reduction above release threshold uses release A, below it release B at once
// RULE2: both release times programmable from 0 to 3000 ms
// RULE3: slope above threshold is one over ratio, ratio from 1 to 17
// RULE4: unity ratio leaves the processed level unchanged
// RULE5: infinite ratio clamps levels above threshold to the threshold
// RULE6: threshold is dBFS, from -79 to 0 dB
// RULE7: soft knee eases from unity to full slope around the threshold
// RULE8: detector takes left, right or the larger magnitude
// RULE9: gain applies to left, right or both; unselected channel passes unchanged
// RULE10: feed-forward detects input, feedback detects own output
// RULE11: main path predelay up to 25 ms relative to the detector
// RULE12: rising level above threshold reduces gain at the attack rate
// RULE13: envelope smoothed by a one-pole lowpass up to 228 ms
// RULE14: active processes, otherwise the signal passes bypassed
// RULE15: output gain has no effect while bypassed
// RULE16: output and make-up gains add in dB, boost capped at 24 dB
// RULE17: present gain reduction is readable as a meter
// RULE18: time constants are one-pole coefficients per sample from time and rate
module dual_release_compressor
   import dual_release_compressor_pkg::*;
#(
   parameter int FS_KHZ = 48,
   parameter int DEPTH  = 2048
)(
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic [AW-1:0] awaddr,
   input  wire logic          awvalid,
   output logic               awready,
   input  wire logic [31:0]   wdata,
   input  wire logic [3:0]    wstrb,
   input  wire logic          wvalid,
   output logic               wready,
   output logic [1:0]         bresp,
   output logic               bvalid,
   input  wire logic          bready,
   input  wire logic [AW-1:0] araddr,
   input  wire logic          arvalid,
   output logic               arready,
   output logic [31:0]        rdata,
   output logic [1:0]         rresp,
   output logic               rvalid,
   input  wire logic          rready,
   input  wire logic          in_valid,
   output logic               in_ready,
   input  wire logic [DW-1:0] in_left,
   input  wire logic [DW-1:0] in_right,
   output logic               out_valid,
   output logic [DW-1:0]      out_left,
   output logic [DW-1:0]      out_right
);
   localparam int AWD = $clog2(DEPTH);
   typedef enum logic [2:0] {S_IDLE, S_LEVEL, S_DIV, S_BALL, S_APPLY} state_e;

   function automatic int cl(input int v, input int lo, input int hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction

   function automatic logic [DW-1:0] sat(input longint v);
      longint hi;
      hi = (longint'(1) <<< (DW - 1)) - 1;
      return (v > hi) ? DW'(hi) : ((v < -hi - 1) ? DW'(-hi - 1) : DW'(v));
   endfunction

   function automatic logic [DW-2:0] mag(input logic [DW-1:0] s);
      int a;
      a = int'($signed(s));
      a = (a < 0) ? -a : a;
      return (a > (1 <<< (DW - 1)) - 1) ? {(DW-1){1'b1}} : (DW-1)'(a);
   endfunction

   // ---------------- register bus ----------------
   logic [31:0]   regs_ff [NREG];
   logic [31:0]   nxt_regs [NREG];
   logic          aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
   logic [AW-1:0] awa_ff, nxt_awa;
   logic [31:0]   wd_ff, nxt_wd;
   logic [3:0]    ws_ff, nxt_ws;
   logic          awready_ff, nxt_awready, wready_ff, nxt_wready;
   logic          bvalid_ff, nxt_bvalid, arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
   logic [1:0]    bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
   logic [31:0]   rdata_ff, nxt_rdata;

   // ---------------- processing state ----------------
   state_e          st_ff, nxt_st;
   logic [2:0]      op_ff, nxt_op;
   logic [5:0]      cnt_ff, nxt_cnt;
   logic [32:0]     rem_ff, nxt_rem;
   logic [31:0]     quo_ff, nxt_quo;
   logic [23:0]     den_ff, nxt_den;
   logic [16:0]     c_ff [4];
   logic [16:0]     nxt_c [4];
   logic [AWD-1:0]  dly_ff, nxt_dly, wp_ff, nxt_wp, rp_ff, nxt_rp;
   logic [16:0]     over_ff, nxt_over, gt_ff, nxt_gt, env_ff, nxt_env, sm_ff, nxt_sm;
   logic            relb_ff, nxt_relb, in_rdy_ff, nxt_in_rdy, out_v_ff, nxt_out_v;
   logic [DW-1:0]   in_l_ff, nxt_in_l, in_r_ff, nxt_in_r;
   logic [DW-1:0]   out_l_ff, nxt_out_l, out_r_ff, nxt_out_r;
   logic [2*DW-1:0] ram_q;
   logic            accept;
   int              thr_c, rel_lim, rr, gain_db;
   logic            inf, active;
   logic [1:0]      chan;

   assign thr_c   = cl(int'($signed(regs_ff[R_COMP_THR][15:0])), THR_MIN, 0); // RULE6
   assign rel_lim = -cl(int'($signed(regs_ff[R_REL_THR][15:0])), THR_MIN, 0);
   assign rr      = cl(int'(regs_ff[R_RATIO][15:0]), RATIO_UNITY, RATIO_MAX); // RULE3
   assign inf     = regs_ff[R_CTRL][B_INF];
   assign active  = regs_ff[R_CTRL][B_ACTIVE];
   assign chan    = regs_ff[R_CTRL][B_CHAN +: 2];
   assign gain_db = cl(cl(int'($signed(regs_ff[R_OUT_GAIN][15:0])), THR_MIN, GAIN_MAX)
                    + cl(int'($signed(regs_ff[R_MAKEUP][15:0])), THR_MIN, GAIN_MAX),
                    2 * THR_MIN, GAIN_MAX); // RULE16
   assign accept  = (st_ff == S_IDLE) && in_valid && in_rdy_ff;

   assign awready   = awready_ff;
   assign wready    = wready_ff;
   assign bvalid    = bvalid_ff;
   assign bresp     = bresp_ff;
   assign arready   = arready_ff;
   assign rvalid    = rvalid_ff;
   assign rresp     = rresp_ff;
   assign rdata     = rdata_ff;
   assign in_ready  = in_rdy_ff;
   assign out_valid = out_v_ff;
   assign out_left  = out_l_ff;
   assign out_right = out_r_ff;

   always_comb begin
      int widx;
      int ridx;
      widx = int'(awa_ff[AW-1:2]);
      ridx = int'(araddr[AW-1:2]);
      nxt_regs    = regs_ff;
      nxt_aw_have = aw_have_ff;
      nxt_w_have  = w_have_ff;
      nxt_awa     = awa_ff;
      nxt_wd      = wd_ff;
      nxt_ws      = ws_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      nxt_rvalid  = rvalid_ff;
      nxt_rresp   = rresp_ff;
      nxt_rdata   = rdata_ff;
      if (awvalid && awready_ff) begin
         nxt_aw_have = 1'b1;
         nxt_awa     = awaddr;
      end
      if (wvalid && wready_ff) begin
         nxt_w_have = 1'b1;
         nxt_wd     = wdata;
         nxt_ws     = wstrb;
      end
      if (bvalid_ff && bready) begin
         nxt_bvalid = 1'b0;
      end
      if (aw_have_ff && w_have_ff && !bvalid_ff) begin
         nxt_aw_have = 1'b0;
         nxt_w_have  = 1'b0;
         nxt_bvalid  = 1'b1;
         nxt_bresp   = (widx < R_METER) ? RESP_OKAY : RESP_SLVERR;
         if (widx < R_METER) begin
            for (int b = 0; b < 4; b++) begin
               if (ws_ff[b]) begin
                  nxt_regs[widx][8*b +: 8] = wd_ff[8*b +: 8];
               end
            end
         end
      end
      if (rvalid_ff && rready) begin
         nxt_rvalid = 1'b0;
      end
      if (arvalid && arready_ff) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = RESP_OKAY;
         nxt_rdata  = 32'h0000_0000;
         if (ridx < R_METER) begin
            nxt_rdata = regs_ff[ridx];
         end else if (ridx == R_METER) begin
            nxt_rdata = {15'h0000, sm_ff}; // RULE17
         end else if (ridx == R_STATUS) begin
            nxt_rdata = {31'h0000_0000, relb_ff};
         end else begin
            nxt_rresp = RESP_SLVERR;
         end
      end
      nxt_awready = !nxt_aw_have;
      nxt_wready  = !nxt_w_have;
      nxt_arready = !nxt_rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NREG; i++) begin
            regs_ff[i] <= 32'h0000_0000;
         end
         regs_ff[R_CTRL]  <= CTRL_RST;
         regs_ff[R_RATIO] <= RATIO_RST;
         aw_have_ff <= 1'b0;
         w_have_ff  <= 1'b0;
         awa_ff     <= '0;
         wd_ff      <= 32'h0000_0000;
         ws_ff      <= 4'h0;
         awready_ff <= 1'b0;
         wready_ff  <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= RESP_OKAY;
         arready_ff <= 1'b0;
         rvalid_ff  <= 1'b0;
         rresp_ff   <= RESP_OKAY;
         rdata_ff   <= 32'h0000_0000;
      end else begin
         regs_ff    <= nxt_regs;
         aw_have_ff <= nxt_aw_have;
         w_have_ff  <= nxt_w_have;
         awa_ff     <= nxt_awa;
         wd_ff      <= nxt_wd;
         ws_ff      <= nxt_ws;
         awready_ff <= nxt_awready;
         wready_ff  <= nxt_wready;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
         arready_ff <= nxt_arready;
         rvalid_ff  <= nxt_rvalid;
         rresp_ff   <= nxt_rresp;
         rdata_ff   <= nxt_rdata;
      end
   end

   delay_ram #(.WIDTH(2 * DW), .DEPTH(DEPTH)) u_ram (
      .aclk  (aclk),
      .we    (accept),
      .waddr (wp_ff),
      .wdata ({in_left, in_right}),
      .raddr (rp_ff),
      .rdata (ram_q)
   );

   always_comb begin
      logic [DW-2:0] m;
      logic [DW-2:0] nrm;
      logic [2:0]    lo;
      logic [32:0]   r;
      logic [DW-1:0] gl;
      logic [DW-1:0] gr;
      int p, lv, ov, x, t, num, den, e, s, coef, ap, l2, ie;
      longint lin;
      m = '0; nrm = '0; r = '0; gl = '0; gr = '0;
      p = 0; lv = FLOOR_DB; ov = 0; x = 0; t = 0; e = 0; s = 0; coef = 0;
      ap = 0; l2 = 0; ie = 0; lin = 0; num = 0; den = 1;
      lo = (st_ff == S_LEVEL) ? 3'h0 : op_ff + 3'h1;
      nxt_st = st_ff; nxt_op = op_ff; nxt_cnt = cnt_ff; nxt_rem = rem_ff; nxt_quo = quo_ff;
      nxt_den = den_ff; nxt_c = c_ff; nxt_dly = dly_ff; nxt_wp = wp_ff; nxt_rp = rp_ff;
      nxt_over = over_ff; nxt_gt = gt_ff; nxt_env = env_ff; nxt_sm = sm_ff; nxt_relb = relb_ff;
      nxt_in_l = in_l_ff; nxt_in_r = in_r_ff; nxt_out_l = out_l_ff; nxt_out_r = out_r_ff;
      nxt_out_v = 1'b0;
      // divider operands for the op about to be loaded
      if (lo < 3'(OP_DLY)) begin
         t   = cl(int'(regs_ff[R_ATK + int'(lo)][15:0]), 0,
                  (lo == 3'h0 || lo == 3'h3) ? T_SM_MAX : T_REL_MAX); // RULE2 RULE13
         num = TIME_NUM;
         den = t * FS_KHZ + TENTHS; // RULE18
      end else if (lo == 3'(OP_DLY)) begin
         num = cl(int'(regs_ff[R_DLY][15:0]), 0, T_DLY_MAX) * FS_KHZ; // RULE11
         den = TENTHS;
      end else begin
         num = inf ? int'(over_ff) : int'(over_ff) * (rr - RATIO_UNITY); // RULE3 RULE4 RULE5
         den = inf ? 1 : rr;
      end
      case (st_ff)
         S_IDLE: begin
            if (accept) begin
               nxt_in_l = in_left;
               nxt_in_r = in_right;
               nxt_wp   = wp_ff + AWD'(1);
               nxt_rp   = wp_ff - dly_ff; // RULE11
               nxt_st   = S_LEVEL;
            end
         end
         S_LEVEL: begin
            case (regs_ff[R_CTRL][B_SRC +: 2]) // RULE8 RULE10
               SEL_L:   m = mag(regs_ff[R_CTRL][B_FDBK] ? out_l_ff : in_l_ff);
               SEL_R:   m = mag(regs_ff[R_CTRL][B_FDBK] ? out_r_ff : in_r_ff);
               default: begin
                  m = mag(regs_ff[R_CTRL][B_FDBK] ? out_l_ff : in_l_ff);
                  if (mag(regs_ff[R_CTRL][B_FDBK] ? out_r_ff : in_r_ff) > m) begin
                     m = mag(regs_ff[R_CTRL][B_FDBK] ? out_r_ff : in_r_ff);
                  end
               end
            endcase
            for (int i = 0; i < DW - 1; i++) begin
               if (m[i]) begin
                  p = i;
               end
            end
            nrm = m << (DW - 2 - p);
            if (m != '0) begin
               lv = int'((longint'((p - (DW - 1)) * DB_ONE + int'(nrm[DW-3 -: FRAC_W]))
                         * DB_PER_LOG2) >>> FRAC_W);
            end
            ov = lv - thr_c;
            x  = ov + (1 <<< (KNEE_SH - 1));
            // soft knee: quadratic blend over a window centred on the threshold
            nxt_over = (x <= 0) ? 17'h0_0000 : ((x >= (1 <<< KNEE_SH)) ? 17'(ov)
                       : 17'((x * x) >>> (KNEE_SH + 1))); // RULE7
            nxt_quo = 32'(num);
            nxt_den = 24'(den);
            nxt_rem = '0;
            nxt_cnt = '0;
            nxt_op  = 3'h0;
            nxt_st  = S_DIV;
         end
         S_DIV: begin
            r       = {rem_ff[31:0], quo_ff[31]};
            nxt_quo = {quo_ff[30:0], 1'b0};
            nxt_rem = r;
            if (r >= {9'h000, den_ff}) begin
               nxt_rem    = r - {9'h000, den_ff};
               nxt_quo[0] = 1'b1;
            end
            nxt_cnt = cnt_ff + 6'h01;
            if (int'(cnt_ff) == DIV_STEPS - 1) begin
               if (op_ff < 3'(OP_DLY)) begin
                  nxt_c[op_ff[1:0]] = (nxt_quo > 32'(ONE_Q16)) ? 17'(ONE_Q16) : nxt_quo[16:0]; // RULE18
               end else if (op_ff == 3'(OP_DLY)) begin
                  nxt_dly = (nxt_quo > 32'(DEPTH - 1)) ? AWD'(DEPTH - 1) : nxt_quo[AWD-1:0];
               end else begin
                  nxt_gt = nxt_quo[16:0];
               end
               if (op_ff == 3'(OP_GAIN)) begin
                  nxt_st = S_BALL;
               end else begin
                  nxt_op  = lo;
                  nxt_quo = 32'(num);
                  nxt_den = 24'(den);
                  nxt_rem = '0;
                  nxt_cnt = '0;
               end
            end
         end
         S_BALL: begin
            e        = int'(env_ff);
            // release step follows the reduction present before this sample
            coef     = (int'(gt_ff) > e) ? int'(c_ff[0]) : ((e > rel_lim) ? int'(c_ff[1]) : int'(c_ff[2])); // RULE12
            e        = e + int'((longint'(int'(gt_ff) - e) * longint'(coef)) >>> Q_SH);
            // status shows the release that the updated reduction selects
            nxt_relb = !(e > rel_lim); // RULE1
            s        = int'(sm_ff);
            s        = s + int'((longint'(e - s) * longint'(int'(c_ff[3]))) >>> Q_SH); // RULE13
            nxt_env  = 17'(e);
            nxt_sm   = 17'(s);
            nxt_st   = S_APPLY;
         end
         S_APPLY: begin
            ap  = gain_db - int'(sm_ff); // RULE16
            l2  = int'((longint'(ap) * LOG2_PER_DB) >>> Q_SH);
            ie  = l2 >>> FRAC_W;
            lin = longint'(ONE_Q16 + (l2 & (DB_ONE - 1)) * (ONE_Q16 / DB_ONE));
            if (ie >= 0) begin
               lin = lin <<< ie;
            end else if (-ie >= Q_SH + FRAC_W + 1) begin
               lin = 0;
            end else begin
               lin = lin >>> (-ie);
            end
            // an off setting of either gain means silence
            if (regs_ff[R_CTRL][B_OG_OFF] || regs_ff[R_CTRL][B_MU_OFF]) begin
               lin = 0;
            end
            gl = sat((longint'($signed(ram_q[2*DW-1:DW])) * lin) >>> Q_SH);
            gr = sat((longint'($signed(ram_q[DW-1:0])) * lin) >>> Q_SH);
            if (active) begin
               nxt_out_l = (chan != SEL_R) ? gl : ram_q[2*DW-1:DW]; // RULE9
               nxt_out_r = (chan != SEL_L) ? gr : ram_q[DW-1:0];
            end else begin
               nxt_out_l = in_l_ff; // RULE14 RULE15
               nxt_out_r = in_r_ff;
            end
            nxt_out_v = 1'b1;
            nxt_st    = S_IDLE;
         end
         default: nxt_st = S_IDLE;
      endcase
      nxt_in_rdy = (nxt_st == S_IDLE);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_ff <= S_IDLE; op_ff <= 3'h0; cnt_ff <= 6'h00; rem_ff <= '0; quo_ff <= 32'h0000_0000;
         den_ff <= 24'h00_0001; dly_ff <= '0; wp_ff <= '0; rp_ff <= '0;
         for (int i = 0; i < 4; i++) begin
            c_ff[i] <= 17'(ONE_Q16);
         end
         over_ff <= '0; gt_ff <= '0; env_ff <= '0; sm_ff <= '0; relb_ff <= 1'b1;
         in_rdy_ff <= 1'b0; out_v_ff <= 1'b0;
         in_l_ff <= '0; in_r_ff <= '0; out_l_ff <= '0; out_r_ff <= '0;
      end else begin
         st_ff <= nxt_st; op_ff <= nxt_op; cnt_ff <= nxt_cnt; rem_ff <= nxt_rem; quo_ff <= nxt_quo;
         den_ff <= nxt_den; dly_ff <= nxt_dly; wp_ff <= nxt_wp; rp_ff <= nxt_rp; c_ff <= nxt_c;
         over_ff <= nxt_over; gt_ff <= nxt_gt; env_ff <= nxt_env; sm_ff <= nxt_sm; relb_ff <= nxt_relb;
         in_rdy_ff <= nxt_in_rdy; out_v_ff <= nxt_out_v;
         in_l_ff <= nxt_in_l; in_r_ff <= nxt_in_r; out_l_ff <= nxt_out_l; out_r_ff <= nxt_out_r;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   a_rel_select: assert property ((st_ff == S_APPLY && int'(env_ff) > rel_lim) |-> !relb_ff) // RULE1
      else $error("release A not chosen above release threshold");
   a_unity_flat: assert property ((st_ff == S_BALL && rr == RATIO_UNITY && !inf) |-> gt_ff == '0) // RULE4
      else $error("unity ratio produced gain reduction");
   a_inf_clamp: assert property ((st_ff == S_BALL && inf) |-> gt_ff == over_ff) // RULE5
      else $error("infinite ratio did not reduce to threshold");
   a_attack_rise: assert property ((st_ff == S_BALL && gt_ff > env_ff) |=> env_ff >= $past(env_ff)) // RULE12
      else $error("envelope fell during attack");
   a_bypass_pass: assert property ((st_ff == S_APPLY && !active) |=> out_valid && out_left == $past(in_l_ff)) // RULE14 RULE15
      else $error("bypass output differs from input");
   a_pass_chan: assert property ((st_ff == S_APPLY && active && chan == SEL_L)
      |=> out_right == $past(ram_q[DW-1:0])) // RULE9
      else $error("unselected channel was modified");
   a_gain_cap: assert property (gain_db <= GAIN_MAX) // RULE16
      else $error("combined gain above cap");
   a_bvalid_hold: assert property ((bvalid && !bready) |=> bvalid && $stable(bresp))
      else $error("write response dropped early");
   a_out_pulse: assert property (out_valid |=> !out_valid ##1 !out_valid)
      else $error("output strobe longer than one cycle");
   c_bypass: cover property (st_ff == S_APPLY && !active);
   c_rel_b: cover property (st_ff == S_BALL ##1 relb_ff && sm_ff != '0);
   c_feedback: cover property (out_valid && regs_ff[R_CTRL][B_FDBK]);
   c_infinite: cover property (st_ff == S_BALL && inf && gt_ff != '0);
endmodule

// [tb/audio_peer.sv]
// Purpose: upstream source and downstream sink of the sample stream
// Assumes: one pair in flight, held until in_ready is sampled high
// Notes:   released data lines show the inverse of the last pair
`timescale 1ns/1ps
module audio_peer
   import dual_release_compressor_pkg::*;
(
   input  wire logic          aclk,
   input  wire logic          in_ready,
   output logic               in_valid,
   output logic [DW-1:0]      in_left,
   output logic [DW-1:0]      in_right,
   input  wire logic          out_valid,
   input  wire logic [DW-1:0] out_left,
   input  wire logic [DW-1:0] out_right
);
   logic [DW-1:0] got_l;
   logic [DW-1:0] got_r;
   int            lat;
   initial begin
      in_valid = 1'b0;
      in_left  = '0;
      in_right = '0;
   end
   task automatic send(input logic [DW-1:0] l, input logic [DW-1:0] r);
      int n;
      @(posedge aclk);
      in_valid <= 1'b1;
      in_left  <= l;
      in_right <= r;
      do @(posedge aclk); while (in_ready !== 1'b1);
      in_valid <= 1'b0;
      in_left  <= ~l;
      in_right <= ~r;
      n = 0;
      do begin
         @(posedge aclk);
         n++;
      end while (out_valid !== 1'b1 && n < 400);
      // seen one edge after the pulse was launched
      lat   = n - 1;
      got_l = out_left;
      got_r = out_right;
   endtask
endmodule

// [tb/tb_top.sv]
// Purpose: self-checking bench of the dual release compressor
// Assumes: AXI4-Lite master and stream peer driven on the rising edge
// Notes:   gains checked by exact pass-through, exact silence or coarse level bounds
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
   $display("Error t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_top;
   import dual_release_compressor_pkg::*;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready, in_valid, in_ready, out_valid;
   logic [AW-1:0] awaddr, araddr;
   logic [31:0]   wdata, rdata, d;
   logic [1:0]    bresp, rresp, r;
   logic [DW-1:0] in_left, in_right, out_left, out_right;
   int            fails, checked, cyc;
   dual_release_compressor dual_release_compressor_inst (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
      .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid), .wready(wready),
      .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .in_valid(in_valid), .in_ready(in_ready),
      .in_left(in_left), .in_right(in_right), .out_valid(out_valid), .out_left(out_left), .out_right(out_right));
   audio_peer audio_peer_inst (.aclk(aclk), .in_ready(in_ready), .in_valid(in_valid), .in_left(in_left),
      .in_right(in_right), .out_valid(out_valid), .out_left(out_left), .out_right(out_right));
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   task automatic print_verdict();
      $display("checks %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge aclk) begin
      cyc++;
      // far above the ~1700 cycles the sequence needs
      if (cyc == 20000) begin
         fails++;
         print_verdict();
      end
   end
   task automatic wr(input int idx, input logic [31:0] v, input logic [1:0] er);
      logic ga, gw;
      @(posedge aclk);
      awaddr <= 8'(4 * idx);
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      ga = 1'b0;
      gw = 1'b0;
      while (!(ga && gw)) begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) begin ga = 1'b1; awvalid <= 1'b0; end
         if (wvalid && wready === 1'b1) begin gw = 1'b1; wvalid <= 1'b0; end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      `CHK(bresp, er)
   endtask
   task automatic rd(input int idx);
      @(posedge aclk);
      araddr <= 8'(4 * idx);
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      d = rdata;
      r = rresp;
   endtask
   task automatic t_regs();
      rd(R_CTRL); `CHK(d, CTRL_RST)
      rd(R_RATIO); `CHK(d, RATIO_RST)
      rd(R_COMP_THR); `CHK(d, 32'h0)
      rd(NREG); `CHK(r, RESP_SLVERR)
      wr(R_METER, 32'h5, RESP_SLVERR);
      rd(R_METER); `CHK(d, 32'h0)
   endtask
   task automatic t_unity();
      audio_peer_inst.send(24'h123456, 24'hF00001);
      `CHK(audio_peer_inst.lat, 3 + 6 * DIV_STEPS)
      `CHK(audio_peer_inst.got_l, 24'h123456)
      `CHK(audio_peer_inst.got_r, 24'hF00001)
   endtask
   task automatic t_bypass();
      wr(R_CTRL, 32'h0, RESP_OKAY);
      wr(R_OUT_GAIN, 32'(GAIN_MAX), RESP_OKAY);
      audio_peer_inst.send(24'h234567, 24'hE00002);
      `CHK(audio_peer_inst.got_l, 24'h234567)
      `CHK(audio_peer_inst.got_r, 24'hE00002)
      wr(R_OUT_GAIN, 32'h0, RESP_OKAY);
   endtask
   task automatic t_clamp();
      wr(R_CTRL, 32'h101, RESP_OKAY);
      wr(R_COMP_THR, 32'(THR_MIN), RESP_OKAY);
      wr(R_REL_A, 32'(T_REL_MAX), RESP_OKAY);
      audio_peer_inst.send(24'h400000, 24'h400000);
      `CHK(audio_peer_inst.got_r, 24'h400000)
      `CHK($signed(audio_peer_inst.got_l) < 24'sh010000, 1'b1)
      rd(R_METER); `CHK(d != 32'h0, 1'b1)
      rd(R_STATUS); `CHK(d[0], 1'b0)
      // slow release A keeps the reduction over a silent pair
      audio_peer_inst.send(24'h0, 24'h0);
      rd(R_METER); `CHK(d != 32'h0, 1'b1)
      wr(R_REL_A, 32'h0, RESP_OKAY);
      audio_peer_inst.send(24'h0, 24'h0);
      rd(R_STATUS); `CHK(d[0], 1'b1)
      rd(R_METER); `CHK(d, 32'h0)
   endtask
   task automatic t_mute();
      wr(R_CTRL, 32'h61, RESP_OKAY);
      audio_peer_inst.send(24'h300000, 24'h300000);
      `CHK(audio_peer_inst.got_l, 24'h0)
      `CHK(audio_peer_inst.got_r, 24'h0)
   endtask
   task automatic t_side();
      // feedback, larger-magnitude detector, right channel only, infinite ratio
      wr(R_CTRL, 32'h11B, RESP_OKAY);
      audio_peer_inst.send(24'h400000, 24'h000010);
      `CHK(audio_peer_inst.got_r, 24'h000010)
      `CHK(audio_peer_inst.got_l, 24'h400000)
      audio_peer_inst.send(24'h400000, 24'h400000);
      `CHK($signed(audio_peer_inst.got_r) < 24'sh010000, 1'b1)
      `CHK(audio_peer_inst.got_l, 24'h400000)
   endtask
   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      fails = 0;
      checked = 0;
      cyc = 0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      t_regs();
      t_unity();
      t_bypass();
      t_clamp();
      t_mute();
      t_side();
      print_verdict();
   end
endmodule
